// ### core/txds_cfg.svh
/*
  Constants of the transmit descriptor status block: bus offsets, word
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from files that also import txds_pkg.
*/
`ifndef TXDS_CFG_SVH
`define TXDS_CFG_SVH
// --------------------
// timing
// --------------------
`define TXDS_CLK_MHZ 125
`define TXDS_ATT_NS 512
`define TXDS_BACKOFF_NS 5120
`define TXDS_HB_NS 4000
`define TXDS_MAX_COLL 16
// --------------------
// sizes
// --------------------
`define TXDS_FIFO_DEPTH 16
`define TXDS_FIFO_WIDTH 33
`define TXDS_PERF_ENTRIES 16
// --------------------
// bus offsets and reset values
// --------------------
`define TXDS_ADR_ISR 8'h00
`define TXDS_ADR_OPM 8'h04
`define TXDS_ADR_RES 8'h08
`define TXDS_ADR_STA 8'h0C
`define TXDS_OPM_RST 32'h00000000
// --------------------
// status word fields
// --------------------
`define TXDS_S_OWN 31
`define TXDS_S_ES 15
`define TXDS_S_EC 8
`define TXDS_S_HF 7
`define TXDS_S_CC_HI 6
`define TXDS_S_CC_LO 3
`define TXDS_S_LF 2
`define TXDS_S_UF 1
`define TXDS_S_DE 0
// --------------------
// control word fields
// --------------------
`define TXDS_C_IC 31
`define TXDS_C_LS 30
`define TXDS_C_FS 29
`define TXDS_C_FT1 28
`define TXDS_C_SET 27
`define TXDS_C_FT0 22
// --------------------
// op mode and interrupt status fields
// --------------------
`define TXDS_O_SYM 23
`define TXDS_O_SPD10 2
`define TXDS_O_TXEN 1
`define TXDS_I_TI 0
`define TXDS_I_TU 5
`define TXDS_FT_PERFECT 2'h0
`endif

// ### core/txds_pkg.sv
/*
  Types of the transmit descriptor status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package txds_pkg;
  typedef enum logic [3:0] {
    TXDS_IDLE,
    TXDS_ATTEMPT,
    TXDS_BACKOFF,
    TXDS_SEND,
    TXDS_HBWAIT,
    TXDS_DRAIN,
    TXDS_NEXT,
    TXDS_SETUP,
    TXDS_WRITE,
    TXDS_SUSP
  } txds_state_t;
  typedef logic [1:0] txds_ftype_t;
endpackage

// ### core/txds_fifo.sv
/*
  Flop-based FIFO with valid/ready on both sides, registered flags.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module txds_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic in_ready_nxt, out_valid_nxt, push, pop;

  assign out_data = mem_r[rp_r];

  always_comb begin
    mem_nxt = mem_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
    // flags from the next count so both stay honest without a bypass path
    in_ready_nxt = cnt_nxt != CW'(DEPTH);
    out_valid_nxt = cnt_nxt != '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= in_ready_nxt;
      out_valid <= out_valid_nxt;
    end
    mem_r <= mem_nxt;
  end
endmodule
`default_nettype wire

// ### core/txds_top.sv
/*
  Transmit descriptor status engine: takes control words, runs attempts,
  drains the data FIFO to the transmitter, writes back the status word,
  loads the setup filter table and keeps two interrupt status bits.
  Assumes a descriptor fetcher, a memory data source, a MAC that reports
  line events, a status writer and a classic Wishbone master.
*/
`timescale 1ns/1ps
`default_nettype none
`include "txds_cfg.svh"
module txds_top
  import txds_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic desc_valid,
  input wire logic [31:0] desc_ctrl,
  output logic desc_ready,
  input wire logic mem_valid,
  input wire logic [31:0] mem_data,
  input wire logic mem_last,
  output logic mem_ready,
  output logic mac_valid,
  output logic [31:0] mac_data,
  output logic mac_last,
  input wire logic mac_ready,
  input wire logic mac_collision,
  input wire logic mac_carrier,
  input wire logic mac_hb_pulse,
  input wire logic mac_link_fail,
  output logic status_valid,
  output logic [31:0] status_word,
  input wire logic status_ready,
  output logic filt_wr,
  output logic [3:0] filt_idx,
  output logic [47:0] filt_addr,
  output logic [1:0] filt_mode
);
  localparam logic [9:0] ATT_CYC = 10'((`TXDS_ATT_NS * `TXDS_CLK_MHZ + 999) / 1000);
  localparam logic [9:0] BO_CYC = 10'((`TXDS_BACKOFF_NS * `TXDS_CLK_MHZ + 999) / 1000);
  localparam logic [9:0] HB_CYC = 10'((`TXDS_HB_NS * `TXDS_CLK_MHZ) / 1000);

  // build a status word; ownership always handed back in the same write
  function automatic logic [31:0] txds_status(input logic uf, input logic ec,
      input logic hf, input logic lf, input logic de, input logic [3:0] cc);
    logic [31:0] w;
    w = 32'h00000000;
    w[`TXDS_S_OWN] = 1'b0;
    w[`TXDS_S_UF] = uf;
    w[`TXDS_S_EC] = ec;
    w[`TXDS_S_HF] = hf;
    w[`TXDS_S_LF] = lf;
    w[`TXDS_S_DE] = de;
    w[`TXDS_S_CC_HI:`TXDS_S_CC_LO] = cc;
    // late collision, carrier and jabber errors are not produced here
    w[`TXDS_S_ES] = uf | ec;
    return w;
  endfunction

  txds_state_t st_r, st_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, sw_r, sw_nxt, md_r, md_nxt, sacc_r, sacc_nxt;
  logic [31:0] op_r, op_nxt, wb_dat_r, wb_dat_nxt;
  logic [4:0] coll_r, coll_nxt, sidx_r, sidx_nxt;
  logic [9:0] tmr_r, tmr_nxt;
  logic [1:0] wp_r, wp_nxt, fm_r, fm_nxt;
  logic [3:0] fi_r, fi_nxt;
  logic [47:0] fa_r, fa_nxt;
  logic dfr_r, dfr_nxt, hf_r, hf_nxt, lf_r, lf_nxt, uf_r, uf_nxt, ec_r, ec_nxt;
  logic mid_r, mid_nxt, sv_r, sv_nxt, dr_r, dr_nxt, mv_r, mv_nxt, ml_r, ml_nxt;
  logic fw_r, fw_nxt, ti_r, ti_nxt, tu_r, tu_nxt, wb_ack_r, wb_ack_nxt;
  logic take, f_ov, f_pop, ti_set, tu_set, uf_evt, resume, bus_go, hs;
  logic [32:0] f_od;

  assign take = desc_valid && dr_r;
  assign hs = sv_r && status_ready;

  txds_fifo #(
    .WIDTH(`TXDS_FIFO_WIDTH),
    .DEPTH(`TXDS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(mem_valid),
    .in_data({mem_last, mem_data}),
    .in_ready(mem_ready),
    .out_valid(f_ov),
    .out_data(f_od),
    .out_ready(f_pop)
  );

  // --------------------
  // register bus
  // --------------------
  always_comb begin
    wb_ack_nxt = 1'b0;
    wb_dat_nxt = wb_dat_r;
    op_nxt = op_r;
    ti_nxt = ti_r;
    tu_nxt = tu_r;
    resume = 1'b0;
    bus_go = wb_cyc_i && wb_stb_i && !wb_ack_r;
    if (bus_go) begin
      wb_ack_nxt = 1'b1;
      wb_dat_nxt = 32'h00000000;
      case (wb_adr_i)
        `TXDS_ADR_ISR: begin
          wb_dat_nxt[`TXDS_I_TI] = ti_r;
          wb_dat_nxt[`TXDS_I_TU] = tu_r;
          if (wb_we_i && wb_sel_i[0]) begin
            if (wb_dat_i[`TXDS_I_TI]) begin
              ti_nxt = 1'b0;
            end
            if (wb_dat_i[`TXDS_I_TU]) begin
              tu_nxt = 1'b0;
            end
          end
        end
        `TXDS_ADR_OPM: begin
          wb_dat_nxt = op_r;
          if (wb_we_i) begin
            for (int i = 0; i < 4; i++) begin
              if (wb_sel_i[i]) begin
                op_nxt[i*8 +: 8] = wb_dat_i[i*8 +: 8];
              end
            end
          end
        end
        `TXDS_ADR_RES: begin
          resume = wb_we_i && wb_sel_i[0];
        end
        `TXDS_ADR_STA: begin
          wb_dat_nxt = {23'h000000, st_r == TXDS_SUSP, 3'h0, coll_r};
        end
        default: begin
          wb_dat_nxt = 32'h00000000;
        end
      endcase
    end
    // a hardware set beats a software clear in the same cycle
    if (ti_set) begin
      ti_nxt = 1'b1;
    end
    if (tu_set) begin
      tu_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h00000000;
      op_r <= `TXDS_OPM_RST;
      ti_r <= 1'b0;
      tu_r <= 1'b0;
    end else begin
      wb_ack_r <= wb_ack_nxt;
      wb_dat_r <= wb_dat_nxt;
      op_r <= op_nxt;
      ti_r <= ti_nxt;
      tu_r <= tu_nxt;
    end
  end

  // --------------------
  // transmit engine
  // --------------------
  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    coll_nxt = coll_r;
    tmr_nxt = tmr_r;
    dfr_nxt = dfr_r;
    hf_nxt = hf_r;
    lf_nxt = lf_r;
    uf_nxt = uf_r;
    ec_nxt = ec_r;
    mid_nxt = mid_r;
    sw_nxt = sw_r;
    sv_nxt = sv_r;
    mv_nxt = mv_r;
    md_nxt = md_r;
    ml_nxt = ml_r;
    wp_nxt = wp_r;
    sidx_nxt = sidx_r;
    sacc_nxt = sacc_r;
    fi_nxt = fi_r;
    fa_nxt = fa_r;
    fm_nxt = fm_r;
    fw_nxt = 1'b0;
    f_pop = 1'b0;
    ti_set = 1'b0;
    tu_set = 1'b0;
    uf_evt = 1'b0;
    if (mv_r && mac_ready) begin
      mv_nxt = 1'b0;
    end
    case (st_r)
      TXDS_IDLE: begin
        if (take) begin
          ctrl_nxt = desc_ctrl;
          coll_nxt = 5'h00;
          {dfr_nxt, hf_nxt, lf_nxt, uf_nxt, ec_nxt, mid_nxt} = 6'h00;
          tmr_nxt = 10'h000;
          if (desc_ctrl[`TXDS_C_SET]) begin
            st_nxt = TXDS_SETUP;
            wp_nxt = 2'h0;
            sidx_nxt = 5'h00;
          end else if (desc_ctrl[`TXDS_C_FS]) begin
            st_nxt = TXDS_ATTEMPT;
            lf_nxt = mac_link_fail && op_r[`TXDS_O_SYM];
          end else begin
            // stray buffer outside a frame: hand it straight back
            sw_nxt = 32'h00000000;
            sv_nxt = 1'b1;
            st_nxt = TXDS_WRITE;
          end
        end
      end
      TXDS_ATTEMPT: begin
        if (mac_carrier) begin
          dfr_nxt = 1'b1;
          tmr_nxt = 10'h000;
        end else if (mac_collision) begin
          coll_nxt = coll_r + 5'h01;
          if (coll_r == 5'(`TXDS_MAX_COLL - 1)) begin
            ec_nxt = 1'b1;
            st_nxt = TXDS_DRAIN;
          end else begin
            st_nxt = TXDS_BACKOFF;
            tmr_nxt = 10'h000;
          end
        end else if (tmr_r < ATT_CYC - 10'h001) begin
          tmr_nxt = tmr_r + 10'h001;
        end else if (f_ov) begin
          st_nxt = TXDS_SEND;
        end
      end
      TXDS_BACKOFF: begin
        if (tmr_r == BO_CYC - 10'h001) begin
          st_nxt = TXDS_ATTEMPT;
          tmr_nxt = 10'h000;
        end else begin
          tmr_nxt = tmr_r + 10'h001;
        end
      end
      TXDS_SEND: begin
        if (!mv_r || mac_ready) begin
          if (f_ov) begin
            f_pop = 1'b1;
            mv_nxt = 1'b1;
            md_nxt = f_od[31:0];
            ml_nxt = f_od[32] && ctrl_r[`TXDS_C_LS];
            if (f_od[32]) begin
              if (!ctrl_r[`TXDS_C_LS]) begin
                // buffer exhausted mid-frame: release it, fetch the next
                sw_nxt = 32'h00000000;
                sv_nxt = 1'b1;
                mid_nxt = 1'b1;
                st_nxt = TXDS_WRITE;
              end else if (op_r[`TXDS_O_SPD10] && coll_r == 5'h00) begin
                st_nxt = TXDS_HBWAIT;
                tmr_nxt = 10'h000;
              end else begin
                sw_nxt = txds_status(1'b0, 1'b0, 1'b0, lf_r, dfr_r, coll_r[3:0]);
                sv_nxt = 1'b1;
                mid_nxt = 1'b0;
                st_nxt = TXDS_WRITE;
              end
            end
          end else if (mac_ready) begin
            uf_evt = 1'b1;
            uf_nxt = 1'b1;
            sw_nxt = txds_status(1'b1, 1'b0, 1'b0, lf_r, dfr_r, coll_r[3:0]);
            sv_nxt = 1'b1;
            mid_nxt = 1'b0;
            st_nxt = TXDS_WRITE;
          end
        end
      end
      TXDS_HBWAIT: begin
        if (mac_hb_pulse || tmr_r == HB_CYC - 10'h001) begin
          hf_nxt = !mac_hb_pulse;
          sw_nxt = txds_status(1'b0, 1'b0, !mac_hb_pulse, lf_r, dfr_r, coll_r[3:0]);
          sv_nxt = 1'b1;
          mid_nxt = 1'b0;
          st_nxt = TXDS_WRITE;
        end else begin
          tmr_nxt = tmr_r + 10'h001;
        end
      end
      TXDS_DRAIN: begin
        // discard the rest of the aborted buffer so it never goes out
        if (f_ov) begin
          f_pop = 1'b1;
          if (f_od[32]) begin
            sw_nxt = txds_status(1'b0, 1'b1, 1'b0, lf_r, dfr_r, coll_r[3:0]);
            sv_nxt = 1'b1;
            mid_nxt = 1'b0;
            st_nxt = TXDS_WRITE;
          end
        end
      end
      TXDS_NEXT: begin
        if (take) begin
          ctrl_nxt = desc_ctrl;
          st_nxt = TXDS_SEND;
        end
      end
      TXDS_SETUP: begin
        if (f_ov) begin
          f_pop = 1'b1;
          wp_nxt = wp_r + 2'h1;
          if (wp_r == 2'h0) begin
            sacc_nxt[15:0] = f_od[15:0];
          end else if (wp_r == 2'h1) begin
            sacc_nxt[31:16] = f_od[15:0];
          end else begin
            wp_nxt = 2'h0;
            fa_nxt = {f_od[15:0], sacc_r};
            fi_nxt = sidx_r[3:0];
            fw_nxt = {ctrl_r[`TXDS_C_FT1], ctrl_r[`TXDS_C_FT0]} == `TXDS_FT_PERFECT
                     && sidx_r < 5'(`TXDS_PERF_ENTRIES);
            sidx_nxt = (sidx_r < 5'(`TXDS_PERF_ENTRIES)) ? sidx_r + 5'h01 : sidx_r;
          end
          if (f_od[32]) begin
            fm_nxt = {ctrl_r[`TXDS_C_FT1], ctrl_r[`TXDS_C_FT0]};
            sw_nxt = 32'h00000000;
            sv_nxt = 1'b1;
            mid_nxt = 1'b0;
            st_nxt = TXDS_WRITE;
          end
        end
      end
      TXDS_WRITE: begin
        if (status_ready) begin
          sv_nxt = 1'b0;
          if (ctrl_r[`TXDS_C_IC] && !mid_r
              && (ctrl_r[`TXDS_C_LS] || ctrl_r[`TXDS_C_SET])) begin
            ti_set = 1'b1;
          end
          if (uf_r) begin
            ti_set = 1'b1;
            tu_set = 1'b1;
            st_nxt = TXDS_SUSP;
          end else if (mid_r) begin
            st_nxt = TXDS_NEXT;
          end else begin
            st_nxt = TXDS_IDLE;
          end
        end
      end
      TXDS_SUSP: begin
        if (resume) begin
          st_nxt = TXDS_IDLE;
        end
      end
      default: begin
        st_nxt = TXDS_IDLE;
      end
    endcase
    dr_nxt = (st_nxt == TXDS_IDLE && op_nxt[`TXDS_O_TXEN]) || st_nxt == TXDS_NEXT;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= TXDS_IDLE;
      ctrl_r <= 32'h00000000;
      sw_r <= 32'h00000000;
      md_r <= 32'h00000000;
      sacc_r <= 32'h00000000;
      coll_r <= 5'h00;
      sidx_r <= 5'h00;
      tmr_r <= 10'h000;
      wp_r <= 2'h0;
      fm_r <= 2'h0;
      fi_r <= 4'h0;
      fa_r <= 48'h000000000000;
      {dfr_r, hf_r, lf_r, uf_r, ec_r, mid_r} <= 6'h00;
      {sv_r, dr_r, mv_r, ml_r, fw_r} <= 5'h00;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      sw_r <= sw_nxt;
      md_r <= md_nxt;
      sacc_r <= sacc_nxt;
      coll_r <= coll_nxt;
      sidx_r <= sidx_nxt;
      tmr_r <= tmr_nxt;
      wp_r <= wp_nxt;
      fm_r <= fm_nxt;
      fi_r <= fi_nxt;
      fa_r <= fa_nxt;
      {dfr_r, hf_r, lf_r, uf_r, ec_r, mid_r} <= {dfr_nxt, hf_nxt, lf_nxt, uf_nxt, ec_nxt, mid_nxt};
      {sv_r, dr_r, mv_r, ml_r, fw_r} <= {sv_nxt, dr_nxt, mv_nxt, ml_nxt, fw_nxt};
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign desc_ready = dr_r;
  assign mac_valid = mv_r;
  assign mac_data = md_r;
  assign mac_last = ml_r;
  assign status_valid = sv_r;
  assign status_word = sw_r;
  assign filt_wr = fw_r;
  assign filt_idx = fi_r;
  assign filt_addr = fa_r;
  assign filt_mode = fm_r;

  // --------------------
  // checks
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ec;
    sv_r && sw_r[`TXDS_S_EC] |-> coll_r == 5'h10 && st_r == TXDS_WRITE;
  endproperty
  a_ec: assert property (p_ec) else $error("excessive collision flag without 16 collisions");
  property p_hf_speed;
    st_r == TXDS_HBWAIT |-> op_r[`TXDS_O_SPD10] && coll_r == 5'h00;
  endproperty
  a_hf_speed: assert property (p_hf_speed) else $error("heartbeat check outside 10Mb/s");
  property p_hf_retry;
    sv_r && coll_r != 5'h00 |-> !sw_r[`TXDS_S_HF];
  endproperty
  a_hf_retry: assert property (p_hf_retry) else $error("heartbeat fail after a retry");
  property p_cc;
    sv_r && !mid_r && ctrl_r[`TXDS_C_LS] && !ctrl_r[`TXDS_C_SET] && !sw_r[`TXDS_S_EC]
      |-> sw_r[`TXDS_S_CC_HI:`TXDS_S_CC_LO] == coll_r[3:0];
  endproperty
  a_cc: assert property (p_cc) else $error("collision count mismatch");
  property p_lf;
    st_r == TXDS_IDLE && take && desc_ctrl[`TXDS_C_FS] && !op_r[`TXDS_O_SYM] |=> !lf_r;
  endproperty
  a_lf: assert property (p_lf) else $error("link fail outside symbol mode");
  property p_uf;
    uf_evt |=> st_r == TXDS_WRITE && sv_r && sw_r[`TXDS_S_UF];
  endproperty
  a_uf: assert property (p_uf) else $error("underflow not reported");
  property p_uf_susp;
    hs && uf_r |=> st_r == TXDS_SUSP && ti_r && tu_r;
  endproperty
  a_uf_susp: assert property (p_uf_susp) else $error("underflow did not suspend");
  property p_def;
    st_r == TXDS_ATTEMPT && mac_carrier |=> dfr_r [*2];
  endproperty
  a_def: assert property (p_def) else $error("deferral not recorded");
  property p_ic;
    hs && ctrl_r[`TXDS_C_IC] && ctrl_r[`TXDS_C_LS] && !mid_r |=> ti_r;
  endproperty
  a_ic: assert property (p_ic) else $error("interrupt on done missing");
  property p_ic_gate;
    hs && !ctrl_r[`TXDS_C_LS] && !ctrl_r[`TXDS_C_SET] && !uf_r && !ti_r |=> !ti_r;
  endproperty
  a_ic_gate: assert property (p_ic_gate) else $error("interrupt without last segment");
  property p_fs;
    st_r == TXDS_IDLE && take && !desc_ctrl[`TXDS_C_FS] && !desc_ctrl[`TXDS_C_SET]
      |=> st_r == TXDS_WRITE && sw_r == 32'h00000000;
  endproperty
  a_fs: assert property (p_fs) else $error("frame started without first segment");
  property p_ft;
    hs && ctrl_r[`TXDS_C_SET] |=> fm_r == {ctrl_r[`TXDS_C_FT1], ctrl_r[`TXDS_C_FT0]};
  endproperty
  a_ft: assert property (p_ft) else $error("filter mode not taken from setup");
  property p_perf;
    fw_r |-> $past(ctrl_r[`TXDS_C_FT1]) == 1'b0 && $past(ctrl_r[`TXDS_C_FT0]) == 1'b0
      && $past(st_r) == TXDS_SETUP;
  endproperty
  a_perf: assert property (p_perf) else $error("perfect table write in wrong mode");
  property p_es;
    sv_r |-> !sw_r[`TXDS_S_OWN] && sw_r[`TXDS_S_ES] == (sw_r[`TXDS_S_UF] | sw_r[`TXDS_S_EC]);
  endproperty
  a_es: assert property (p_es) else $error("bad ownership or error summary");
endmodule
`default_nettype wire

// ### bench/txds_host.sv
/*
  Host model: offers control words, feeds buffer data, takes status.
  Assumes valid/ready handshakes on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module txds_host (
  input wire logic clk,
  output logic desc_valid = 1'b0,
  output logic [31:0] desc_ctrl = 32'h0,
  input wire logic desc_ready,
  output logic mem_valid = 1'b0,
  output logic [31:0] mem_data = 32'h0,
  output logic mem_last = 1'b0,
  input wire logic mem_ready,
  output logic status_ready = 1'b0
);
  // ----
  // host side
  // ----
  logic [1:0] cnt = 2'h0;
  // status writer stalls two cycles in four
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    status_ready <= cnt[1];
  end
  // buffer flags come from the caller as software sets them
  task automatic send(input logic [31:0] c, input int n, input int gap, input logic [31:0] d);
    @(posedge clk);
    fork
      begin
        desc_valid <= 1'b1;
        desc_ctrl <= c;
        do @(posedge clk); while (desc_ready !== 1'b1);
        desc_valid <= 1'b0;
        desc_ctrl <= ~c;
      end
      for (int i = 0; i < n; i++) begin
        if (i == 2 && gap > 0) begin
          // late memory, only when a scenario asks for it
          mem_valid <= 1'b0;
          mem_data <= ~mem_data;
          repeat (gap) @(posedge clk);
        end
        mem_valid <= 1'b1;
        mem_data <= d + i;
        mem_last <= (i == n - 1);
        do @(posedge clk); while (mem_ready !== 1'b1);
        if (i == n - 1) begin
          // drop at once: a late descriptor must not push the last word twice
          mem_valid <= 1'b0;
          mem_data <= ~mem_data;
          mem_last <= 1'b0;
        end
      end
    join
  endtask
endmodule
`default_nettype wire

// ### bench/txds_top_tb_top.sv
/*
  Testbench of the transmit descriptor status engine.
  Assumes the host model is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module txds_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_ack_o, desc_valid, desc_ready, mem_valid, mem_last, mem_ready;
  logic [31:0] wb_dat_o, desc_ctrl, mem_data, mac_data, status_word, rd;
  logic mac_valid, mac_last, status_valid, status_ready;
  logic mac_ready = 1'b0;
  logic mac_collision = 1'b0;
  logic mac_carrier = 1'b0;
  logic mac_link_fail = 1'b0;
  logic mac_hb_pulse = 1'b0;
  logic filt_wr;
  logic [3:0] filt_idx;
  logic [47:0] filt_addr;
  logic [1:0] filt_mode;
  logic [31:0] fd = 32'h0;
  logic [32:0] qd[$];
  int nf = 0;
  logic [31:0] seed = 32'h97E7;
  logic [31:0] qe[$];
  logic [31:0] qm[$];
  int errors = 0;
  int n_compared = 0;
  // ----
  // harness
  // ----
  always #4 clk = ~clk;
  txds_top uut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .desc_valid, .desc_ctrl, .desc_ready, .mem_valid,
    .mem_data, .mem_last, .mem_ready, .mac_valid, .mac_data, .mac_last, .mac_ready,
    .mac_collision, .mac_carrier, .mac_hb_pulse, .mac_link_fail, .status_valid,
    .status_word, .status_ready, .filt_wr, .filt_idx, .filt_addr, .filt_mode);
  txds_host host (.clk, .desc_valid, .desc_ctrl, .desc_ready, .mem_valid, .mem_data,
    .mem_last, .mem_ready, .status_ready);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  always @(posedge clk) mac_ready <= ^xs();
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e, input logic [31:0] m);
    qe.push_back(e & m);
    qm.push_back(m);
  endtask
  // frame words that should reach the transmitter are noted before they are offered
  task automatic tx(input logic [31:0] c, input int n, input int gap, input int nout);
    fd = xs();
    for (int i = 0; i < nout; i++) qd.push_back({c[30] && (i == n - 1), fd + 32'(i)});
    host.send(c, n, gap, fd);
  endtask
  task automatic done(input string s);
    while (qe.size() != 0 || qd.size() != 0) @(posedge clk);
    $display("test %s done", s);
  endtask
  // the word that hands a buffer back is compared under the mask queued with it
  always @(posedge clk) begin
    if (status_valid === 1'b1 && status_ready === 1'b1) begin
      if (qe.size() == 0) chk(status_word, 32'hFFFFFFFF);
      else begin
        chk(status_word & qm[0], qe[0]);
        void'(qe.pop_front());
        void'(qm.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    if (mac_valid === 1'b1 && mac_ready === 1'b1) begin
      if (qd.size() == 0) chk({31'h0, mac_last}, 32'hFFFFFFFF);
      else begin
        chk(mac_data, qd[0][31:0]);
        chk({31'h0, mac_last}, {31'h0, qd[0][32]});
        void'(qd.pop_front());
      end
    end
  end
  // setup words come three to an entry, lowest half first
  always @(posedge clk) begin
    if (filt_wr === 1'b1) begin
      chk(filt_addr[31:0], {fd[15:0] + 16'(3 * nf + 1), fd[15:0] + 16'(3 * nf)});
      chk({12'h0, filt_idx, filt_addr[47:32]},
          {12'h0, nf[3:0], fd[15:0] + 16'(3 * nf + 2)});
      nf++;
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h04, 32'h2);
    st(32'h0, '1);
    tx(32'hE0000000, 4, 0, 4);
    done("frame");
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, 8'h00, 32'h1);
    st(32'h0, '1);
    st(32'h0, '1);
    tx(32'hA0000000, 2, 0, 2);
    tx(32'h40000000, 2, 0, 2);
    done("segments");
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    st(32'h1, '1);
    mac_carrier <= 1'b1;
    fork tx(32'h60000000, 4, 0, 4); join_none
    repeat (40) @(posedge clk);
    mac_carrier <= 1'b0;
    done("deferred");
    // count is not meaningful beside excessive collisions
    st(32'h8100, 32'hFFFFFF87);
    mac_collision <= 1'b1;
    tx(32'h60000000, 4, 0, 0);
    done("collisions");
    mac_collision <= 1'b0;
    wb(1'b1, 8'h04, 32'h00800006);
    mac_link_fail <= 1'b1;
    // no test pulse returns, as with a transceiver that lacks the check
    st(32'h84, '1);
    tx(32'h60000000, 3, 0, 3);
    done("heartbeat");
    mac_link_fail <= 1'b0;
    st(32'h08, '1);
    fork tx(32'h60000000, 3, 0, 3); join_none
    repeat (10) @(posedge clk);
    mac_collision <= 1'b1;
    @(posedge clk);
    mac_collision <= 1'b0;
    done("retry");
    mac_hb_pulse <= 1'b1;
    st(32'h0, '1);
    tx(32'h60000000, 3, 0, 3);
    done("heartbeat ok");
    mac_hb_pulse <= 1'b0;
    st(32'h0, '1);
    tx(32'h88000000, 6, 0, 0);
    done("setup perfect");
    chk(nf, 32'h2);
    chk({30'h0, filt_mode}, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, 8'h00, 32'h1);
    st(32'h0, '1);
    tx(32'h18000000, 3, 0, 0);
    done("setup other");
    chk({30'h0, filt_mode}, 32'h2);
    chk(nf, 32'h2);
    wb(1'b1, 8'h04, 32'h2);
    // heartbeat is meaningless beside underflow
    st(32'h8002, 32'hFFFFFF7F);
    tx(32'h60000000, 6, 300, 2);
    done("underflow");
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h21);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'h100, 32'h100);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'h100, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
